/* pkg/psrf_pkg.sv */
// Purpose: constants and types for the pll synthesis and reset flag block
// Assumes: 8-bit register port, 25 MHz clock
// Notes: register offsets 0x03..0x06, interrupt registers at 0x20..0x22
package psrf_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	// register offsets
	localparam logic [7:0] ADDR_RESET_FLAGS = 8'h03;
	localparam logic [7:0] ADDR_MULTIPLIER = 8'h04;
	localparam logic [7:0] ADDR_REF_DIVIDER = 8'h05;
	localparam logic [7:0] ADDR_OUT_DIVIDER = 8'h06;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h21;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h22;
	// reset flag bit positions
	localparam int POS_POWER_ON = 6;
	localparam int POS_LOW_VOLTAGE = 5;
	localparam int POS_WATCHDOG = 3;
	localparam int POS_OSC_LOSS = 1;
	localparam int POS_PLL_LOSS = 0;
	// field positions
	localparam int POS_VCO_RANGE = 6;
	localparam int POS_REF_RANGE = 6;
	// interrupt status bit positions
	localparam int POS_IRQ_LOCK_CHG = 0;
	localparam int POS_IRQ_OSC_CHG = 1;
	localparam int POS_IRQ_RAMP_DONE = 2;
	localparam int POS_IRQ_WR_REFUSED = 3;
	localparam int IRQ_W = 4;
	// values after reset
	// power-on and low-voltage flags come up set
	localparam logic [7:0] RST_RESET_FLAGS = 8'h60;
	localparam logic [7:0] RST_MULTIPLIER = 8'h00;
	localparam logic [7:0] RST_REF_DIVIDER = 8'h00;
	localparam logic [4:0] RST_OUT_DIVIDER = 5'h00;
	localparam logic [1:0] FILTER_INTERNAL = 2'h0;
	// unlocked output divisor is four, stored as ratio minus one
	localparam logic [4:0] DIV_UNLOCKED = 5'h03;
	// bus clock is half the pll output
	localparam int BUS_CLK_RATIO = 2;
	localparam int RAMP_BUS_CYCLES = 32;
	localparam int RAMP_CLK_CYCLES = RAMP_BUS_CYCLES * BUS_CLK_RATIO;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic [1:0] vco_range_sel;
		logic [5:0] loop_multiplier;
		logic [1:0] ref_range_sel;
		logic [3:0] reference_divider;
	} psrf_synth_cfg_t;

	typedef struct packed {
		logic [7:0] vco_mult;
		logic [4:0] ref_div;
		logic [5:0] out_div;
		logic [6:0] bus_div;
	} psrf_ratio_t;
endpackage : psrf_pkg

/* hdl/psrf_top.sv */
// Purpose: reset cause flags and pll frequency synthesis registers
// Assumes: i_rst_n is the power-on reset, i_sys_rst a synchronous system reset
// Notes: lock and oscillator status arrive asynchronous and are filtered
`timescale 1ns/100ps

// Functional notes
// - power-on sets power-on flag, system reset keeps
// - low voltage or power-on sets low-voltage flag
// - watchdog reset sets flag, power-on clears
// - oscillator monitor reset sets flag, power-on clears
// - pll monitor reset sets flag, power-on clears
// - flags clear only by writing one
// - multiplier, divider writes need unprotected, pll selected
// - accepted synth write clears lock, qualified
// - vco equals two times reference times multiplier+1
// - reference is oscillator/(divider+1) or internal 1MHz
// - internal reference pins filter to 1-2MHz range
// - output divider write needs only pll selected
// - output is vco/(divider+1) locked, vco/4 unlocked
// - bus clock is half pll output
// - output divider ramps to target within 32 bus cycles
module psrf_top #(
	parameter int RAMP_LIMIT = psrf_pkg::RAMP_BUS_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_sys_rst,
	input wire logic [psrf_pkg::ADDR_W-1:0] i_addr,
	input wire logic [psrf_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_lvr_event,
	input wire logic i_watchdog_event,
	input wire logic i_osc_loss_event,
	input wire logic i_pll_loss_event,
	input wire logic i_pll_lock_raw,
	input wire logic i_osc_qualified_raw,
	input wire logic i_write_protect,
	input wire logic i_pll_source_select,
	input wire logic i_ext_oscillator_enable,
	output logic [psrf_pkg::DATA_W-1:0] o_rdata,
	output logic o_irq,
	output logic o_pll_locked,
	output logic o_oscillator_qualified,
	output logic o_relock_pulse,
	output logic o_ref_internal,
	output logic [1:0] o_filter_range,
	output psrf_pkg::psrf_synth_cfg_t o_synth_cfg,
	output psrf_pkg::psrf_ratio_t o_ratio
);
	if (RAMP_LIMIT < 31)
		$error("ramp limit must cover 31 divider steps");

	logic [7:0] reset_flags;
	logic [7:0] multiplier;
	logic [7:0] ref_divider;
	logic [4:0] out_divider;
	logic [4:0] cur_div;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] filt;
	logic lock_hold;
	logic osc_hold;
	logic bus_tick;
	logic ramping;
	logic [psrf_pkg::IRQ_W-1:0] irq_status;
	logic [psrf_pkg::IRQ_W-1:0] irq_enable;
	logic [7:0] next_rdata;
	logic [4:0] next_target;
	logic wr_flags;
	logic wr_mult;
	logic wr_reference_divider;
	logic wr_outdiv;
	logic synth_ok;
	logic synth_acc;
	logic outdiv_acc;
	logic refused;
	logic lock_chg;
	logic osc_chg;
	logic ramp_done;
	logic [7:0] flag_set;

	assign wr_flags = i_wr && (i_addr == psrf_pkg::ADDR_RESET_FLAGS);
	assign wr_mult = i_wr && (i_addr == psrf_pkg::ADDR_MULTIPLIER);
	assign wr_reference_divider = i_wr && (i_addr == psrf_pkg::ADDR_REF_DIVIDER);
	assign wr_outdiv = i_wr && (i_addr == psrf_pkg::ADDR_OUT_DIVIDER);
	assign synth_ok = !i_write_protect && i_pll_source_select;
	assign synth_acc = (wr_mult || wr_reference_divider) && synth_ok;
	assign outdiv_acc = wr_outdiv && i_pll_source_select;
	assign refused = ((wr_mult || wr_reference_divider) && !synth_ok) || (wr_outdiv && !i_pll_source_select);

	// reset cause events, one bit per flag position except power-on
	always_comb
	begin
		flag_set = 8'h00;
		flag_set[psrf_pkg::POS_LOW_VOLTAGE] = i_lvr_event;
		flag_set[psrf_pkg::POS_WATCHDOG] = i_watchdog_event;
		flag_set[psrf_pkg::POS_OSC_LOSS] = i_osc_loss_event;
		flag_set[psrf_pkg::POS_PLL_LOSS] = i_pll_loss_event;
	end

	// flags survive the system reset, only power-on touches them
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			reset_flags <= psrf_pkg::RST_RESET_FLAGS;
		end
		else if (i_ce)
		begin
			reset_flags <= (reset_flags & ~(wr_flags ? i_wdata : 8'h00)) | flag_set;
		end
	end

	// synthesis registers
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			multiplier <= psrf_pkg::RST_MULTIPLIER;
			ref_divider <= psrf_pkg::RST_REF_DIVIDER;
			out_divider <= psrf_pkg::RST_OUT_DIVIDER;
		end
		else if (i_ce)
		begin
			if (i_sys_rst)
			begin
				multiplier <= psrf_pkg::RST_MULTIPLIER;
				ref_divider <= psrf_pkg::RST_REF_DIVIDER;
				out_divider <= psrf_pkg::RST_OUT_DIVIDER;
			end
			else
			begin
				if (wr_mult && synth_ok)
					multiplier <= i_wdata;
				// range bits stored even on internal reference
				if (wr_reference_divider && synth_ok)
					ref_divider <= {i_wdata[7:6], 2'h0, i_wdata[3:0]};
				if (outdiv_acc)
					out_divider <= i_wdata[4:0];
			end
		end
	end

	// status inputs come from the analog loop, three stages, agreement filter
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			sync3 <= 2'h0;
			filt <= 2'h0;
		end
		else if (i_ce)
		begin
			sync1 <= {i_osc_qualified_raw, i_pll_lock_raw};
			sync2 <= sync1;
			sync3 <= sync2;
			for (int i = 0; i < 2; i++)
			begin
				if (sync2[i] == sync3[i])
					filt[i] <= sync3[i];
			end
		end
	end

	// a stale lock must not survive a new synthesis setting
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lock_hold <= 1'b0;
			osc_hold <= 1'b0;
			o_pll_locked <= 1'b0;
			o_oscillator_qualified <= 1'b0;
			o_relock_pulse <= 1'b0;
		end
		else if (i_ce)
		begin
			o_relock_pulse <= synth_acc && !i_sys_rst;
			if (synth_acc && !i_sys_rst)
			begin
				lock_hold <= 1'b1;
				osc_hold <= 1'b1;
				o_pll_locked <= 1'b0;
				o_oscillator_qualified <= 1'b0;
			end
			else
			begin
				lock_hold <= lock_hold && filt[0];
				osc_hold <= osc_hold && filt[1];
				o_pll_locked <= filt[0] && !lock_hold;
				o_oscillator_qualified <= filt[1] && !osc_hold;
			end
		end
	end

	assign next_target = o_pll_locked ? out_divider : psrf_pkg::DIV_UNLOCKED;

	// one divider step per bus clock, at most 31 steps
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			bus_tick <= 1'b0;
			cur_div <= psrf_pkg::DIV_UNLOCKED;
			ramping <= 1'b0;
		end
		else if (i_ce)
		begin
			bus_tick <= !bus_tick;
			if (!o_pll_locked)
				cur_div <= psrf_pkg::DIV_UNLOCKED;
			else if (bus_tick && cur_div < next_target)
				cur_div <= cur_div + 5'h01;
			else if (bus_tick && cur_div > next_target)
				cur_div <= cur_div - 5'h01;
			ramping <= o_pll_locked && (cur_div != next_target);
		end
	end

	assign lock_chg = o_pll_locked != (filt[0] && !lock_hold && !synth_acc);
	assign osc_chg = o_oscillator_qualified != (filt[1] && !osc_hold && !synth_acc);
	assign ramp_done = ramping && (cur_div == next_target);

	// interrupt status, set wins over the clear write
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			irq_status <= '0;
			irq_enable <= '0;
			o_irq <= 1'b0;
		end
		else if (i_ce)
		begin
			if (i_sys_rst)
			begin
				irq_status <= '0;
				irq_enable <= '0;
				o_irq <= 1'b0;
			end
			else
			begin
				irq_status <= (irq_status
					& ~((i_wr && i_addr == psrf_pkg::ADDR_IRQ_CLEAR)
						? i_wdata[psrf_pkg::IRQ_W-1:0] : '0))
					| {refused, ramp_done, osc_chg, lock_chg};
				if (i_wr && i_addr == psrf_pkg::ADDR_IRQ_ENABLE)
					irq_enable <= i_wdata[psrf_pkg::IRQ_W-1:0];
				o_irq <= |(irq_status & irq_enable);
			end
		end
	end

	// read mux, unmapped and write-only read as zero
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (i_addr)
			psrf_pkg::ADDR_RESET_FLAGS: next_rdata = reset_flags;
			psrf_pkg::ADDR_MULTIPLIER: next_rdata = multiplier;
			psrf_pkg::ADDR_REF_DIVIDER: next_rdata = ref_divider;
			psrf_pkg::ADDR_OUT_DIVIDER: next_rdata = {3'h0, out_divider};
			psrf_pkg::ADDR_IRQ_STATUS: next_rdata = {4'h0, irq_status};
			psrf_pkg::ADDR_IRQ_ENABLE: next_rdata = {4'h0, irq_enable};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_ce)
			o_rdata <= i_rd ? next_rdata : 8'h00;
	end

	// ratio and configuration outputs for the analog loop
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_synth_cfg <= '0;
			o_ratio <= '0;
			o_ref_internal <= 1'b1;
			o_filter_range <= psrf_pkg::FILTER_INTERNAL;
		end
		else if (i_ce)
		begin
			o_synth_cfg <= {multiplier[7:6], multiplier[5:0], ref_divider[7:6], ref_divider[3:0]};
			o_ratio.vco_mult <= {1'b0, multiplier[5:0], 1'b0} + 8'h02;
			// reference from oscillator or internal source
			o_ratio.ref_div <= i_ext_oscillator_enable ? {1'b0, ref_divider[3:0]} + 5'h01 : 5'h01;
			o_ref_internal <= !i_ext_oscillator_enable;
			o_filter_range <= i_ext_oscillator_enable ? ref_divider[7:6] : psrf_pkg::FILTER_INTERNAL;
			o_ratio.out_div <= {1'b0, cur_div} + 6'h01;
			o_ratio.bus_div <= ({1'b0, cur_div} + 6'h01) * 7'h02;
		end
	end

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [7:0] ramp_cnt;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ramp_cnt <= 8'h00;
		else if (i_ce && (outdiv_acc || i_sys_rst))
			ramp_cnt <= 8'h00;
		else if (i_ce)
			ramp_cnt <= (o_pll_locked && cur_div != next_target) ? ramp_cnt + 8'h01 : 8'h00;
	end
	sequence s_synth_accept;
		i_ce && synth_acc && !i_sys_rst;
	endsequence
	sequence s_status_dropped;
		!o_pll_locked && !o_oscillator_qualified && o_relock_pulse;
	endsequence
	por_no_set_a: assert property (!$rose(reset_flags[psrf_pkg::POS_POWER_ON]))
		else $error("power-on flag rose without power-on");
	lvr_flag_set_a: assert property (i_ce && i_lvr_event |=> reset_flags[5])
		else $error("low-voltage flag not set");
	wdog_flag_set_a: assert property (i_ce && i_watchdog_event |=> reset_flags[3])
		else $error("watchdog flag not set");
	osc_flag_set_a: assert property (i_ce && i_osc_loss_event |=> reset_flags[1])
		else $error("oscillator loss flag not set");
	pll_flag_set_a: assert property (i_ce && i_pll_loss_event |=> reset_flags[0])
		else $error("pll loss flag not set");
	flag_w1c_a: assert property (i_ce && wr_flags && i_wdata[6] |=> !reset_flags[6])
		else $error("flag not cleared by writing one");
	flag_keep_a: assert property (i_ce && wr_flags && i_wdata == 8'h00 && flag_set == 8'h00
		|=> $stable(reset_flags))
		else $error("flags changed on zero write");
	mult_gate_a: assert property (i_ce && wr_mult && i_write_protect && !i_sys_rst
		|=> $stable(multiplier))
		else $error("protected multiplier write took effect");
	relock_clear_a: assert property (s_synth_accept |=> s_status_dropped)
		else $error("accepted write did not drop lock status");
	outdiv_gate_a: assert property (i_ce && wr_outdiv && !i_pll_source_select && !i_sys_rst
		|=> $stable(out_divider))
		else $error("output divider write taken without pll select");
	unlocked_div_a: assert property (i_ce && !o_pll_locked |=> cur_div == 5'h03)
		else $error("unlocked divisor not four");
	filter_int_a: assert property (i_ce && !i_ext_oscillator_enable |=> o_filter_range == 2'h0)
		else $error("filter range not fixed on internal reference");
	ramp_bound_a: assert property (ramp_cnt <= 8'(RAMP_LIMIT * 2))
		else $error("divider ramp exceeded its bound");
endmodule : psrf_top

/* verif/testbench.sv */
// Purpose: self-checking bench for the pll synthesis and reset flag block
// Assumes: bench drives every port itself, single 25 MHz clock
// Notes: lock input is toggled by hand, since the loop itself is not modelled
`timescale 1ns/100ps
module testbench;
	logic i_clk;
	logic i_rst_n;
	logic i_ce;
	logic i_sys_rst;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [3:0] ev_bus;
	logic i_pll_lock_raw;
	logic i_osc_qualified_raw;
	logic i_write_protect;
	logic i_pll_source_select;
	logic i_ext_oscillator_enable;
	logic [7:0] o_rdata;
	logic o_irq;
	logic o_pll_locked;
	logic o_oscillator_qualified;
	logic o_relock_pulse;
	logic o_ref_internal;
	logic [1:0] o_filter_range;
	psrf_pkg::psrf_synth_cfg_t o_synth_cfg;
	psrf_pkg::psrf_ratio_t o_ratio;
	int error_cnt;
	int check_count;
	logic [7:0] rd_val;

	psrf_top #(.RAMP_LIMIT(32)) psrf_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_lvr_event(ev_bus[3]), .i_watchdog_event(ev_bus[2]), .i_osc_loss_event(ev_bus[1]),
		.i_pll_loss_event(ev_bus[0]), .i_pll_lock_raw(i_pll_lock_raw),
		.i_osc_qualified_raw(i_osc_qualified_raw), .i_write_protect(i_write_protect),
		.i_pll_source_select(i_pll_source_select),
		.i_ext_oscillator_enable(i_ext_oscillator_enable), .o_rdata(o_rdata), .o_irq(o_irq),
		.o_pll_locked(o_pll_locked), .o_oscillator_qualified(o_oscillator_qualified),
		.o_relock_pulse(o_relock_pulse), .o_ref_internal(o_ref_internal),
		.o_filter_range(o_filter_range), .o_synth_cfg(o_synth_cfg), .o_ratio(o_ratio));

	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	task automatic check(input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : check

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		rd_val = o_rdata;
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		check(e, rd_val);
	endtask : rd_chk

	task automatic ev(input logic [3:0] v);
		@(posedge i_clk);
		ev_bus <= v;
		@(posedge i_clk);
		ev_bus <= 4'h0;
		#1;
	endtask : ev

	// bounded wait for the ramp, then the cycle budget is judged
	task automatic wait_div(input logic [5:0] e);
		int n;
		n = 0;
		while (n < 100 && o_ratio.out_div !== e)
		begin
			cyc(1);
			n++;
		end
		if (o_ratio.out_div !== e)
		begin
			error_cnt++;
			final_report();
		end
		else
			check(8'h01, {7'h0, n <= psrf_pkg::RAMP_CLK_CYCLES});
	endtask : wait_div

	task automatic t_flags();
		rd_chk(8'h03, 8'h60);
		wr(8'h03, 8'h20);
		rd_chk(8'h03, 8'h40);
		ev(4'hf);
		rd_chk(8'h03, 8'h6b);
		wr(8'h03, 8'h00);
		rd_chk(8'h03, 8'h6b);
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		@(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd_chk(8'h03, 8'h6b);
		wr(8'h03, 8'h08);
		rd_chk(8'h03, 8'h63);
		i_ce <= 1'b0;
		wr(8'h03, 8'h63);
		i_ce <= 1'b1;
		rd_chk(8'h03, 8'h63);
		wr(8'h03, 8'h63);
		rd_chk(8'h03, 8'h00);
		$display("test flags done");
	endtask : t_flags

	task automatic t_synth();
		i_write_protect <= 1'b1;
		i_pll_source_select <= 1'b1;
		wr(8'h04, 8'h4a);
		rd_chk(8'h04, 8'h00);
		i_write_protect <= 1'b0;
		i_pll_source_select <= 1'b0;
		wr(8'h04, 8'h4a);
		wr(8'h05, 8'h81);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h05, 8'h00);
		i_pll_source_select <= 1'b1;
		check(8'h01, {7'h0, o_pll_locked});
		wr(8'h04, 8'h45);
		check(8'h01, {7'h0, o_relock_pulse});
		check(8'h00, {7'h0, o_pll_locked});
		check(8'h00, {7'h0, o_oscillator_qualified});
		wr(8'h05, 8'h83);
		rd_chk(8'h04, 8'h45);
		rd_chk(8'h05, 8'h83);
		cyc(2);
		check(8'h0c, o_ratio.vco_mult);
		check(8'h45, {o_synth_cfg.vco_range_sel, o_synth_cfg.loop_multiplier});
		check(8'h23, {2'h0, o_synth_cfg.ref_range_sel, o_synth_cfg.reference_divider});
		check(8'h04, {3'h0, o_ratio.ref_div});
		check(8'h02, {6'h0, o_filter_range});
		i_ext_oscillator_enable <= 1'b0;
		cyc(3);
		check(8'h01, {3'h0, o_ratio.ref_div});
		check(8'h01, {7'h0, o_ref_internal});
		check(8'h00, {6'h0, o_filter_range});
		i_ext_oscillator_enable <= 1'b1;
		$display("test synth done");
	endtask : t_synth

	task automatic t_post();
		i_pll_source_select <= 1'b0;
		wr(8'h06, 8'h07);
		rd_chk(8'h06, 8'h00);
		i_pll_source_select <= 1'b1;
		i_write_protect <= 1'b1;
		wr(8'h06, 8'h07);
		rd_chk(8'h06, 8'h07);
		// lock only returns after the raw input falls and rises again
		i_pll_lock_raw <= 1'b0;
		cyc(8);
		i_pll_lock_raw <= 1'b1;
		cyc(10);
		check(8'h01, {7'h0, o_pll_locked});
		wait_div(6'h08);
		check(8'h10, {1'b0, o_ratio.bus_div});
		i_pll_lock_raw <= 1'b0;
		wait_div(6'h04);
		i_pll_lock_raw <= 1'b1;
		$display("test post done");
	endtask : t_post

	task automatic t_irq();
		wr(8'h21, 8'h0f);
		wr(8'h22, 8'h08);
		rd_chk(8'h22, 8'h08);
		wr(8'h04, 8'h11);
		cyc(2);
		check(8'h01, {7'h0, o_irq});
		rd(8'h20);
		check(8'h08, rd_val & 8'h08);
		wr(8'h21, 8'h08);
		cyc(2);
		check(8'h00, {7'h0, o_irq});
		wr(8'h22, 8'h00);
		wr(8'h04, 8'h11);
		cyc(2);
		check(8'h00, {7'h0, o_irq});
		rd_chk(8'h04, 8'h45);
		wr(8'h30, 8'h55);
		rd_chk(8'h30, 8'h00);
		i_write_protect <= 1'b0;
		$display("test irq done");
	endtask : t_irq

	initial
	begin
		error_cnt = 0;
		check_count = 0;
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		i_sys_rst = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		ev_bus = 4'h0;
		i_pll_lock_raw = 1'b1;
		i_osc_qualified_raw = 1'b1;
		i_write_protect = 1'b0;
		i_pll_source_select = 1'b0;
		i_ext_oscillator_enable = 1'b1;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		cyc(12);
		t_flags();
		t_synth();
		t_post();
		t_irq();
		final_report();
	end

	// hang guard far above the test length, at 50000 cycles
	initial
	begin
		#2000000;
		error_cnt++;
		final_report();
	end
endmodule : testbench
